//--- design/short_confirm.v
// Confirms a short detection after the first detection and three retries.
// Assumes DETECT is already synchronised to CLK.
`include "step_gen_defines.vh"

module short_confirm (
    input wire CLK,
    input wire RST,
    input wire DETECT,
    output reg CONFIRM
);

    reg det_q;
    reg [1:0] tries;
    reg [7:0] gap;
    wire rise;
    wire gap_done;

    assign rise = DETECT & ~det_q;
    assign gap_done = (gap == `SHORT_GAP_CYC);

    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            det_q <= 1'b0;
            tries <= 2'h0;
            gap <= 8'h00;
            CONFIRM <= 1'b0;
        end else begin
            det_q <= DETECT;
            CONFIRM <= 1'b0;
            if (rise) begin
                gap <= 8'h00;
                // A lone spurious detection never gets past the count
                if (tries == `SHORT_RETRIES) begin
                    tries <= 2'h0;
                    CONFIRM <= 1'b1;
                end else begin
                    tries <= tries + 2'h1;
                end
            end else if (gap_done) begin
                tries <= 2'h0;
            end else if (tries != 2'h0) begin
                gap <= gap + 8'h01;
            end
        end
    end

endmodule

//--- design/step_gen_defines.vh
// Constants for the step generator, index output and diagnostics block.
// Assumes a 40 MHz reference clock and a 32-bit APB register bus.
`ifndef STEP_GEN_DEFINES_VH
`define STEP_GEN_DEFINES_VH

// Register byte addresses
`define REG_GLOBAL_CONFIG 8'h00
`define REG_VELOCITY 8'h04
`define REG_POSITION 8'h08
`define REG_DRIVER_STATUS 8'h0c
`define REG_INT_STATUS 8'h10
`define REG_INT_MASK 8'h14

// Global configuration fields
`define CFG_STEP_TOGGLE 0
`define CFG_DRV_ENABLE 1
`define CFG_OT_LO 2
`define CFG_OT_HI 3
`define CFG_OT_SERIAL 4
`define CFG_WIDTH 5
`define CFG_RESET 5'h00

// Velocity and position
`define VEL_WIDTH 24
`define VEL_RESET 24'h000000
`define POS_WIDTH 10
`define POS_MAX 10'h3ff
`define POS_RESET 10'h000

// Temperature comparator levels, index into the sensor vector
`define TL_120 2'h0
`define TL_143 2'h1
`define TL_150 2'h2
`define TL_157 2'h3

// Overtemperature settings: shutdown / pre-warning
`define OTS_143_120 2'h0
`define OTS_150_120 2'h1
`define OTS_150_143 2'h2
`define OTS_157_143 2'h3

// Driver status word fields
`define DS_OTPW 0
`define DS_OT 1
`define DS_SG_A 2
`define DS_SG_B 3
`define DS_SS_A 4
`define DS_SS_B 5
`define DS_BR_A 6
`define DS_BR_B 7
`define DS_WIDTH 8

// Interrupt status and mask fields
`define INT_OTPW 0
`define INT_OT 1
`define INT_SHORT_A 2
`define INT_SHORT_B 3
`define INT_INDEX 4
`define INT_WIDTH 5
`define INT_RESET 5'h00

// Short confirmation
`define SHORT_RETRIES 2'h3
`define SHORT_GAP_NS 2000
`define CLK_PERIOD_NS 25
`define SHORT_GAP_CYC (`SHORT_GAP_NS / `CLK_PERIOD_NS)

`endif

//--- design/step_generator_index_diagnostics.v
// Internal step pulse generator, index output and diagnostic protection.
// Assumes APB master on REF_CLK; sensor and short pins are asynchronous.
`include "step_gen_defines.vh"

module step_generator_index_diagnostics (
    input wire REF_CLK,
    input wire RST,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    input wire [3:0] TEMP_ABOVE,
    input wire [1:0] OTP_OT_SEL,
    input wire SHORT_GND_A,
    input wire SHORT_GND_B,
    input wire SHORT_SUP_A,
    input wire SHORT_SUP_B,
    output reg BRIDGE_A_EN,
    output reg BRIDGE_B_EN,
    output reg STEP_PULSE,
    output reg STEP_DIR,
    output reg INDEX,
    output reg IRQ
);

    // Shutdown comparator level for a setting
    function [1:0] shut_level;
        input [1:0] setting;
        begin
            case (setting)
                `OTS_143_120: shut_level = `TL_143;
                `OTS_150_120: shut_level = `TL_150;
                `OTS_150_143: shut_level = `TL_150;
                default: shut_level = `TL_157;
            endcase
        end
    endfunction

    // Pre-warning comparator level for a setting
    function [1:0] warn_level;
        input [1:0] setting;
        begin
            case (setting)
                `OTS_143_120: warn_level = `TL_120;
                `OTS_150_120: warn_level = `TL_120;
                default: warn_level = `TL_143;
            endcase
        end
    endfunction

    // Comparator output at a level
    function above_at;
        input [3:0] above;
        input [1:0] level;
        begin
            above_at = above[level];
        end
    endfunction

    // Pin synchronisers: first stage read only by the second
    reg [9:0] pin_meta;
    reg [9:0] pin_sync;

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            pin_meta <= 10'h000;
            pin_sync <= 10'h000;
        end else begin
            pin_meta <= {OTP_OT_SEL, SHORT_SUP_B, SHORT_SUP_A,
                         SHORT_GND_B, SHORT_GND_A, TEMP_ABOVE};
            pin_sync <= pin_meta;
        end
    end

    wire [3:0] temp_above = pin_sync[3:0];
    wire det_sg_a = pin_sync[4];
    wire det_sg_b = pin_sync[5];
    wire det_ss_a = pin_sync[6];
    wire det_ss_b = pin_sync[7];
    // Two synced bits may disagree for a cycle; take the setting once stable
    reg [1:0] otp_prev;
    reg [1:0] otp_sel;

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            otp_prev <= 2'h0;
            otp_sel <= 2'h0;
        end else begin
            otp_prev <= pin_sync[9:8];
            if (pin_sync[9:8] == otp_prev) begin
                otp_sel <= otp_prev;
            end
        end
    end

    // Registers
    reg [`CFG_WIDTH-1:0] global_config;
    reg [`VEL_WIDTH-1:0] velocity_setpoint;
    reg [`POS_WIDTH-1:0] microstep_position_count;
    reg [`INT_WIDTH-1:0] int_status;
    reg [`INT_WIDTH-1:0] int_mask;

    wire step_toggle_select = global_config[`CFG_STEP_TOGGLE];
    wire drv_enable = global_config[`CFG_DRV_ENABLE];

    // APB decode
    wire setup = PSEL & ~PENABLE;
    wire access = PSEL & PENABLE;
    wire mapped = (PADDR == `REG_GLOBAL_CONFIG) | (PADDR == `REG_VELOCITY) |
                  (PADDR == `REG_POSITION) | (PADDR == `REG_DRIVER_STATUS) |
                  (PADDR == `REG_INT_STATUS) | (PADDR == `REG_INT_MASK);
    wire wr = access & PWRITE & mapped;
    wire rd_int = access & ~PWRITE & (PADDR == `REG_INT_STATUS);

    assign PREADY = access;
    assign PSLVERR = access & ~mapped;

    // Threshold selection, serial overrides the programmed setting
    wire [1:0] cfg_ot = global_config[`CFG_OT_HI:`CFG_OT_LO];
    // The highest setting cannot come from the programmed store
    wire [1:0] otp_ot = (otp_sel == `OTS_157_143) ? `OTS_150_143 : otp_sel;
    wire [1:0] ot_setting = global_config[`CFG_OT_SERIAL] ? cfg_ot : otp_ot;
    wire hot_warn = above_at(temp_above, warn_level(ot_setting));
    wire hot_shut = above_at(temp_above, shut_level(ot_setting));

    reg overtemp_shutdown_flag;
    reg prewarn_flag;
    reg prewarn_q;

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            overtemp_shutdown_flag <= 1'b0;
            prewarn_flag <= 1'b0;
            prewarn_q <= 1'b0;
        end else begin
            prewarn_flag <= hot_warn;
            prewarn_q <= prewarn_flag;
            if (hot_shut) begin
                overtemp_shutdown_flag <= 1'b1;
            end else if (~hot_warn) begin
                overtemp_shutdown_flag <= 1'b0;
            end
        end
    end

    // Short confirmation per bridge and type
    wire conf_sg_a;
    wire conf_sg_b;
    wire conf_ss_a;
    wire conf_ss_b;

    short_confirm u_sg_a (.CLK(REF_CLK), .RST(RST), .DETECT(det_sg_a), .CONFIRM(conf_sg_a));
    short_confirm u_sg_b (.CLK(REF_CLK), .RST(RST), .DETECT(det_sg_b), .CONFIRM(conf_sg_b));
    short_confirm u_ss_a (.CLK(REF_CLK), .RST(RST), .DETECT(det_ss_a), .CONFIRM(conf_ss_a));
    short_confirm u_ss_b (.CLK(REF_CLK), .RST(RST), .DETECT(det_ss_b), .CONFIRM(conf_ss_b));

    reg short_ground_bridge_a;
    reg short_ground_bridge_b;
    reg short_supply_bridge_a;
    reg short_supply_bridge_b;
    reg enable_q;
    wire re_enable = drv_enable & ~enable_q;

    // Confirmation wins over a clear in the same cycle
    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            enable_q <= 1'b0;
            short_ground_bridge_a <= 1'b0;
            short_ground_bridge_b <= 1'b0;
            short_supply_bridge_a <= 1'b0;
            short_supply_bridge_b <= 1'b0;
        end else begin
            enable_q <= drv_enable;
            short_ground_bridge_a <= conf_sg_a |
                                     (short_ground_bridge_a & ~re_enable);
            short_ground_bridge_b <= conf_sg_b |
                                     (short_ground_bridge_b & ~re_enable);
            short_supply_bridge_a <= conf_ss_a |
                                     (short_supply_bridge_a & ~re_enable);
            short_supply_bridge_b <= conf_ss_b |
                                     (short_supply_bridge_b & ~re_enable);
        end
    end

    wire short_a = short_ground_bridge_a | short_supply_bridge_a;
    wire short_b = short_ground_bridge_b | short_supply_bridge_b;
    wire drive_ok = drv_enable & ~overtemp_shutdown_flag;

    // Only the shorted bridge is switched off, until re-enable clears it
    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            BRIDGE_A_EN <= 1'b0;
            BRIDGE_B_EN <= 1'b0;
        end else begin
            BRIDGE_A_EN <= drive_ok & ~short_a & ~conf_sg_a & ~conf_ss_a;
            BRIDGE_B_EN <= drive_ok & ~short_b & ~conf_sg_b & ~conf_ss_b;
        end
    end

    // Step generator: phase accumulator on the velocity magnitude
    reg [`VEL_WIDTH-1:0] phase;
    wire vel_neg = velocity_setpoint[`VEL_WIDTH-1];
    wire [`VEL_WIDTH-1:0] vel_mag = vel_neg ? (~velocity_setpoint + 24'h000001)
                                            : velocity_setpoint;
    wire [`VEL_WIDTH:0] phase_sum = {1'b0, phase} + {1'b0, vel_mag};
    wire step_now = phase_sum[`VEL_WIDTH];

    reg [`POS_WIDTH-1:0] next_position;

    always @* begin
        next_position = microstep_position_count;
        if (step_now) begin
            if (vel_neg) begin
                next_position = (microstep_position_count == `POS_RESET) ? `POS_MAX
                                : microstep_position_count - 10'h001;
            end else begin
                next_position = (microstep_position_count == `POS_MAX) ? `POS_RESET
                                : microstep_position_count + 10'h001;
            end
        end
    end

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            phase <= `VEL_RESET;
            microstep_position_count <= `POS_RESET;
            STEP_PULSE <= 1'b0;
            STEP_DIR <= 1'b0;
        end else begin
            phase <= phase_sum[`VEL_WIDTH-1:0];
            microstep_position_count <= next_position;
            STEP_PULSE <= step_now;
            STEP_DIR <= vel_neg;
        end
    end

    // Index output: zero point of the sequence, or a toggle per step
    wire at_zero = (next_position == `POS_RESET);
    wire index_event = step_now & at_zero;

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            INDEX <= 1'b0;
        end else if (step_toggle_select) begin
            if (step_now) begin
                INDEX <= ~INDEX;
            end
        end else begin
            INDEX <= at_zero;
        end
    end

    // Sticky interrupt events
    reg ot_q;
    wire [`INT_WIDTH-1:0] events;

    assign events[`INT_OTPW] = prewarn_flag & ~prewarn_q;
    assign events[`INT_OT] = overtemp_shutdown_flag & ~ot_q;
    assign events[`INT_SHORT_A] = conf_sg_a | conf_ss_a;
    assign events[`INT_SHORT_B] = conf_sg_b | conf_ss_b;
    assign events[`INT_INDEX] = index_event;

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            ot_q <= 1'b0;
            int_status <= `INT_RESET;
            IRQ <= 1'b0;
        end else begin
            ot_q <= overtemp_shutdown_flag;
            // A new event in the reading cycle stays set
            if (rd_int) begin
                int_status <= events;
            end else begin
                int_status <= int_status | events;
            end
            IRQ <= |(next_int_or(int_status, events, rd_int) & int_mask);
        end
    end

    // Status value that the interrupt output follows
    function [`INT_WIDTH-1:0] next_int_or;
        input [`INT_WIDTH-1:0] cur;
        input [`INT_WIDTH-1:0] ev;
        input clr;
        begin
            next_int_or = clr ? ev : (cur | ev);
        end
    endfunction

    // Writable registers
    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            global_config <= `CFG_RESET;
            velocity_setpoint <= `VEL_RESET;
            int_mask <= `INT_RESET;
        end else if (wr) begin
            case (PADDR)
                `REG_GLOBAL_CONFIG: global_config <= PWDATA[`CFG_WIDTH-1:0];
                `REG_VELOCITY: velocity_setpoint <= PWDATA[`VEL_WIDTH-1:0];
                `REG_INT_MASK: int_mask <= PWDATA[`INT_WIDTH-1:0];
                default: global_config <= global_config;
            endcase
        end
    end

    // Read data captured in the setup cycle
    wire [`DS_WIDTH-1:0] driver_status_word = {BRIDGE_B_EN, BRIDGE_A_EN,
        short_supply_bridge_b, short_supply_bridge_a,
        short_ground_bridge_b, short_ground_bridge_a,
        overtemp_shutdown_flag, prewarn_flag};

    reg [31:0] next_rdata;

    always @* begin
        case (PADDR)
            `REG_GLOBAL_CONFIG: next_rdata = {27'h0000000, global_config};
            `REG_VELOCITY: next_rdata = {8'h00, velocity_setpoint};
            `REG_POSITION: next_rdata = {22'h000000, microstep_position_count};
            `REG_DRIVER_STATUS: next_rdata = {24'h000000, driver_status_word};
            `REG_INT_STATUS: next_rdata = {27'h0000000, int_status | events};
            `REG_INT_MASK: next_rdata = {27'h0000000, int_mask};
            default: next_rdata = 32'h00000000;
        endcase
    end

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            PRDATA <= 32'h00000000;
        end else if (setup & ~PWRITE) begin
            PRDATA <= next_rdata;
        end
    end

endmodule

//--- verif/host_apb.sv
// Host processor model: reaches the block's registers over APB.
// Assumes the bench timeout cuts short a slave that never answers.
`include "step_gen_defines.vh"
module host_apb (
    input wire clk,
    input wire pready,
    input wire pslverr,
    input wire [31:0] prdata,
    output logic psel = 1'b0,
    output logic penable = 1'b0,
    output logic pwrite = 1'b0,
    output logic [7:0] paddr = 8'h00,
    output logic [31:0] pwdata = 32'h00000000
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        xfer(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
        xfer(1'b0, a, 32'h0, q, e);
    endtask
    // Velocity changes in small increments to spare the motor
    task automatic ramp(input logic [23:0] from, input logic [23:0] to);
        logic [23:0] v;
        v = from;
        while (v != to) begin
            v = (to > v) ? v + 24'h100000 : v - 24'h100000;
            wr(`REG_VELOCITY, {8'h00, v});
        end
    endtask
endmodule

//--- verif/step_gen_monitor.sv
// Port assertions for the step generator, index and diagnostics block.
// Assumes it is bound to the top module; one clock domain on REF_CLK.
module step_gen_monitor (
    input wire REF_CLK,
    input wire RST,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [31:0] PRDATA,
    input wire PREADY,
    input wire PSLVERR,
    input wire [3:0] TEMP_ABOVE,
    input wire [1:0] OTP_OT_SEL,
    input wire SHORT_GND_A,
    input wire SHORT_GND_B,
    input wire SHORT_SUP_A,
    input wire SHORT_SUP_B,
    input wire BRIDGE_A_EN,
    input wire BRIDGE_B_EN,
    input wire STEP_PULSE,
    input wire STEP_DIR,
    input wire INDEX,
    input wire IRQ
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);
    property p_ready; PSEL && PENABLE |-> PREADY; endproperty
    a_ready: assert property (p_ready) else $error("no ready in access");
    property p_err; PSEL && PENABLE && PADDR > 8'h14 |-> PSLVERR; endproperty
    a_err: assert property (p_err) else $error("no error on unmapped access");
    property p_err_idle; !PENABLE |-> !PSLVERR; endproperty
    a_err_idle: assert property (p_err_idle) else $error("error outside access");
    property p_quiet; $fell(RST) |-> !STEP_PULSE && !IRQ && !INDEX && !BRIDGE_A_EN; endproperty
    a_quiet: assert property (p_quiet) else $error("outputs active after reset");
    property p_step_gap; STEP_PULSE |=> !STEP_PULSE; endproperty
    a_step_gap: assert property (p_step_gap) else $error("steps too close");
    property p_ot_off; TEMP_ABOVE == 4'hf [*8] |-> !BRIDGE_A_EN && !BRIDGE_B_EN; endproperty
    a_ot_off: assert property (p_ot_off) else $error("bridge on while hot");
    property p_ot_hold;
        TEMP_ABOVE == 4'hf [*8] ##1 TEMP_ABOVE[1] [*8] |-> !BRIDGE_A_EN && !BRIDGE_B_EN;
    endproperty
    a_ot_hold: assert property (p_ot_hold) else $error("bridge back too early");
    property p_irq_clr; PSEL && PENABLE && !PWRITE && PADDR == 8'h10 |-> ##2 !IRQ; endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("irq kept after status read");
    c_step: cover property (STEP_PULSE);
    c_bridge_off: cover property ($fell(BRIDGE_A_EN));
    c_irq: cover property ($rose(IRQ));
endmodule

//--- verif/testbench.sv
// Self-checking bench for the step generator, index and diagnostics block.
// Assumes the host model on APB and design/ on the include path.
`include "step_gen_defines.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] temp = 4'h0;
    logic [1:0] otp = 2'h0;
    logic [3:0] shorts = 4'h0;
    logic idx_q = 1'b0;
    logic rerr;
    logic [31:0] rdata;
    wire psel, penable, pwrite, pready, pslverr, bra, brb, stp, dir, idx, irq;
    wire [7:0] paddr;
    wire [31:0] pwdata, prdata;
    int bad_count = 0;
    int n_checks = 0;
    int steps = 0;
    int idx_rise = 0;
    int idx_chg = 0;
    int cycles = 0;
    int sdn[4] = '{2, 3, 3, 4};
    int pwn[4] = '{1, 1, 2, 2};
    host_apb host (.clk(clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    step_generator_index_diagnostics i_step_generator_index_diagnostics (.REF_CLK(clk),
        .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .TEMP_ABOVE(temp), .OTP_OT_SEL(otp), .SHORT_GND_A(shorts[0]), .SHORT_GND_B(shorts[1]),
        .SHORT_SUP_A(shorts[2]), .SHORT_SUP_B(shorts[3]), .BRIDGE_A_EN(bra), .BRIDGE_B_EN(brb),
        .STEP_PULSE(stp), .STEP_DIR(dir), .INDEX(idx), .IRQ(irq));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic end_of_test();
        if (bad_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        idx_q <= idx;
        steps <= steps + int'(stp);
        idx_rise <= idx_rise + int'(idx & ~idx_q);
        idx_chg <= idx_chg + int'(idx ^ idx_q);
        if (cycles == 20000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        host.rd(a, rdata, rerr);
        check(rdata, e);
    endtask
    function automatic logic [3:0] therm(input int n);
        return 4'((1 << n) - 1);
    endfunction
    task automatic t_regs();
        rdc(`REG_GLOBAL_CONFIG, 32'h0);
        rdc(`REG_VELOCITY, 32'h0);
        rdc(`REG_DRIVER_STATUS, 32'h0);
        rdc(`REG_INT_MASK, 32'h0);
        check(idx, 1'b1);
        host.wr(8'h18, 32'h1f);
        rdc(8'h18, 32'h0);
        check(rerr, 1'b1);
        host.wr(`REG_POSITION, 32'h5);
        rdc(`REG_POSITION, 32'h0);
    endtask
    task automatic t_steps();
        int s0, r0, n, p1, w;
        host.wr(`REG_INT_MASK, 32'h10);
        s0 = steps;
        host.wr(`REG_VELOCITY, 32'h400000);
        w = 0;
        while (stp !== 1'b1 && w < 8) begin
            @(posedge clk);
            w++;
        end
        check(w < 8, 1'b1);
        tick(2044);
        host.wr(`REG_VELOCITY, 32'h0);
        tick(4);
        n = steps - s0;
        check(n >= 510 && n <= 515, 1'b1);
        host.rd(`REG_POSITION, rdata, rerr);
        p1 = int'(rdata);
        check(p1, n);
        check(idx, p1 == 0);
        s0 = steps;
        r0 = idx_rise;
        host.wr(`REG_VELOCITY, 32'hc00000);
        tick(2000);
        check(dir, 1'b1);
        tick(2096);
        host.wr(`REG_VELOCITY, 32'h0);
        tick(4);
        n = steps - s0;
        rdc(`REG_POSITION, 32'((p1 - n) & 'h3ff));
        check(idx_rise - r0, n >= p1 ? 1 + (n - p1) / 1024 : 0);
        check(irq, 1'b1);
        rdc(`REG_INT_STATUS, 32'h10);
        tick(2);
        check(irq, 1'b0);
    endtask
    task automatic t_toggle();
        int s0, c0;
        host.wr(`REG_GLOBAL_CONFIG, 32'h1);
        tick(4);
        s0 = steps;
        c0 = idx_chg;
        host.ramp(24'h000000, 24'h400000);
        tick(500);
        host.ramp(24'h400000, 24'h000000);
        tick(4);
        check(idx_chg - c0, steps - s0);
        check(steps > s0 + 100, 1'b1);
        host.wr(`REG_GLOBAL_CONFIG, 32'h0);
    endtask
    task automatic t_temp();
        for (int s = 0; s < 4; s++) begin
            host.wr(`REG_GLOBAL_CONFIG, 32'h12 | (s << 2));
            temp <= therm(sdn[s] - 1);
            tick(8);
            check({brb, bra}, 2'h3);
            temp <= therm(sdn[s]);
            tick(8);
            check({brb, bra}, 2'h0);
            temp <= therm(pwn[s]);
            tick(8);
            check({brb, bra}, 2'h0);
            rdc(`REG_DRIVER_STATUS, 32'h03);
            temp <= therm(pwn[s] - 1);
            tick(8);
            rdc(`REG_DRIVER_STATUS, 32'hc0);
        end
        host.wr(`REG_INT_MASK, 32'h0);
        host.rd(`REG_INT_STATUS, rdata, rerr);
        otp <= 2'h3;
        host.wr(`REG_GLOBAL_CONFIG, 32'h2);
        temp <= 4'h7;
        tick(8);
        check({irq, bra}, 2'h0);
        host.wr(`REG_INT_MASK, 32'h2);
        tick(2);
        check(irq, 1'b1);
        temp <= 4'h3;
        tick(8);
        check(bra, 1'b0);
        temp <= 4'h1;
        tick(8);
        check(bra, 1'b1);
        rdc(`REG_INT_STATUS, 32'h3);
        tick(2);
        check(irq, 1'b0);
        temp <= 4'h0;
    endtask
    task automatic pulses(input int k, input int b);
        repeat (k) begin
            shorts[b] <= 1'b1;
            tick(3);
            shorts[b] <= 1'b0;
            tick(20);
        end
    endtask
    task automatic t_short();
        for (int b = 0; b < 4; b++) begin
            pulses(3, b);
            tick(8);
            check({brb, bra}, 2'h3);
            tick(100);
            pulses(4, b);
            tick(8);
            check({brb, bra}, b[0] ? 2'h1 : 2'h2);
            rdc(`REG_INT_STATUS, b[0] ? 32'h8 : 32'h4);
            host.wr(`REG_GLOBAL_CONFIG, 32'h0);
            rdc(`REG_DRIVER_STATUS, 32'h4 << b);
            host.wr(`REG_GLOBAL_CONFIG, 32'h2);
            tick(4);
            rdc(`REG_DRIVER_STATUS, 32'hc0);
        end
    endtask
    initial begin
        tick(16);
        rst <= 1'b0;
        tick(2);
        t_regs();
        t_steps();
        t_toggle();
        t_temp();
        t_short();
        end_of_test();
    end
endmodule
bind step_generator_index_diagnostics step_gen_monitor i_mon (.REF_CLK, .RST, .PSEL,
    .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .TEMP_ABOVE,
    .OTP_OT_SEL, .SHORT_GND_A, .SHORT_GND_B, .SHORT_SUP_A, .SHORT_SUP_B, .BRIDGE_A_EN,
    .BRIDGE_B_EN, .STEP_PULSE, .STEP_DIR, .INDEX, .IRQ);
